// File: hdl/pio_pkg.sv
// package for the parallel io ports block: offsets, resets, carrier types
package pio_pkg;
  localparam int PIO_PORTS = 3;
  localparam int PIO_WIDTH = 8;
  localparam int PIO_FIXED_WIDTH = 8;
  // word offsets (index); byte address = 4 * index
  localparam logic [3:0] PIO_OFS_DATA0 = 4'h0;
  localparam logic [3:0] PIO_OFS_DATA1 = 4'h1;
  localparam logic [3:0] PIO_OFS_DATA2 = 4'h2;
  localparam logic [3:0] PIO_OFS_DIR0 = 4'h4;
  localparam logic [3:0] PIO_OFS_DIR1 = 4'h5;
  localparam logic [3:0] PIO_OFS_DIR2 = 4'h6;
  localparam logic [3:0] PIO_OFS_FIXED = 4'h8;
  localparam logic [3:0] PIO_OFS_SERCTL = 4'h9;
  // serial control register bit positions
  localparam int PIO_SERCTL_RXEN = 0;
  localparam int PIO_SERCTL_TXEN = 1;
  localparam int PIO_SERCTL_SPIEN = 2;
  // fixed port line positions
  localparam int PIO_FX_RX = 0;
  localparam int PIO_FX_TX = 1;
  localparam int PIO_FX_SPI_LO = 2;
  localparam int PIO_FX_SPI_HI = 5;
  localparam int PIO_FX_UNUSED = 6;
  // reset values
  localparam logic [7:0] PIO_DIR_RST = 8'h00;
  localparam logic [7:0] PIO_DATA_RST = 8'h00;
  localparam logic [2:0] PIO_SERCTL_RST = 3'h0;
  localparam logic [31:0] PIO_RDATA_RST = 32'h0000_0000;
  localparam logic [31:0] PIO_UNMAPPED = 32'h0000_0000;

  typedef enum logic [0:0] {PIO_IDLE, PIO_DONE} pio_state_t;

  typedef struct packed {
    logic [PIO_WIDTH-1:0] latch;
    logic [PIO_WIDTH-1:0] dir;
  } pio_port_t;

  typedef struct packed {
    pio_state_t state;
    pio_port_t [PIO_PORTS-1:0] port;
    logic [2:0] serctl;
    logic [31:0] rdata;
  } pio_regs_t;
endpackage : pio_pkg

// File: hdl/pio_top.sv
// parallel io ports: three bidirectional ports and a fixed input port
// Functional notes
// - three 8-bit ports, each with direction register
// - direction one drives output, zero is input
// - reset clears all direction registers
// - direction registers read back last written
// - data write to input pin only updates latch
// - data write to output pin drives latch
// - input pin reads live pin level
// - output pin reads latch, not pin
// - seven-line fixed input port; serial functions override
// - fixed lines: rx, tx, then four spi
// - rx and tx read zero only with both enabled; spi on reads zero, spi off reads pins
// - fixed port reads pins at read time
`timescale 1ns/1ps
module pio_top
  import pio_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // avalon-mm slave
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // first port pins
  input wire logic [7:0] i_first_port_pins,
  output logic [7:0] o_first_port_pins,
  output logic [7:0] o_first_port_pins_oe,
  // second port pins
  input wire logic [7:0] i_second_port_pins,
  output logic [7:0] o_second_port_pins,
  output logic [7:0] o_second_port_pins_oe,
  // third port pins
  input wire logic [7:0] i_third_port_pins,
  output logic [7:0] o_third_port_pins,
  output logic [7:0] o_third_port_pins_oe,
  // fixed input port pins, bit 6 unused
  input wire logic [7:0] i_fixed_input_port_pins,
  // serial enables, visible to the serial units
  output logic o_async_serial_rx_en,
  output logic o_async_serial_tx_en,
  output logic o_spi_en
);

  pio_regs_t r;
  pio_regs_t next_r;
  logic [PIO_WIDTH-1:0] pin_in [PIO_PORTS];
  logic [3:0] idx;
  logic [31:0] rd_val;
  logic access;

  assign pin_in[0] = i_first_port_pins;
  assign pin_in[1] = i_second_port_pins;
  assign pin_in[2] = i_third_port_pins;
  assign idx = i_avs_address[5:2];
  assign access = (i_avs_read | i_avs_write) && (r.state == PIO_IDLE);

  // input bits come from the pin, output bits from the latch
  function automatic logic [7:0] port_read(input logic [7:0] latch,
                                           input logic [7:0] dir,
                                           input logic [7:0] pins);
    port_read = (dir & latch) | (~dir & pins);
  endfunction : port_read

  // merge byte lane 0 only; upper lanes hold no bits
  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0] be);
    lane0 = be[0] ? wd[7:0] : old;
  endfunction : lane0

  // fixed port read: spi owns its lines while enabled; rx and tx only while both are enabled
  function automatic logic [7:0] fixed_read(input logic [7:0] pins,
                                            input logic [2:0] ctl);
    logic [7:0] v;
    v = pins;
    v[PIO_FX_UNUSED] = 1'b0;
    if (ctl[PIO_SERCTL_RXEN] && ctl[PIO_SERCTL_TXEN]) begin
      v[PIO_FX_TX:PIO_FX_RX] = 2'b00;
    end
    if (ctl[PIO_SERCTL_SPIEN]) begin
      v[PIO_FX_SPI_HI:PIO_FX_SPI_LO] = 4'h0;
    end
    fixed_read = v;
  endfunction : fixed_read

  always_comb begin
    rd_val = PIO_UNMAPPED;
    case (idx)
      PIO_OFS_DATA0: rd_val[7:0] = port_read(r.port[0].latch, r.port[0].dir, pin_in[0]);
      PIO_OFS_DATA1: rd_val[7:0] = port_read(r.port[1].latch, r.port[1].dir, pin_in[1]);
      PIO_OFS_DATA2: rd_val[7:0] = port_read(r.port[2].latch, r.port[2].dir, pin_in[2]);
      PIO_OFS_DIR0: rd_val[7:0] = r.port[0].dir;
      PIO_OFS_DIR1: rd_val[7:0] = r.port[1].dir;
      PIO_OFS_DIR2: rd_val[7:0] = r.port[2].dir;
      PIO_OFS_FIXED: rd_val[7:0] = fixed_read(i_fixed_input_port_pins, r.serctl);
      PIO_OFS_SERCTL: rd_val[2:0] = r.serctl;
      default: rd_val = PIO_UNMAPPED;
    endcase
  end

  always_comb begin
    next_r = r;
    case (r.state)
      PIO_IDLE: begin
        if (access) begin
          // one wait cycle so read data come from a flip-flop
          next_r.state = PIO_DONE;
          if (i_avs_read) begin
            next_r.rdata = rd_val;
          end
          if (i_avs_write) begin
            case (idx)
              PIO_OFS_DATA0: next_r.port[0].latch = lane0(r.port[0].latch, i_avs_writedata,
                                                          i_avs_byteenable);
              PIO_OFS_DATA1: next_r.port[1].latch = lane0(r.port[1].latch, i_avs_writedata,
                                                          i_avs_byteenable);
              PIO_OFS_DATA2: next_r.port[2].latch = lane0(r.port[2].latch, i_avs_writedata,
                                                          i_avs_byteenable);
              PIO_OFS_DIR0: next_r.port[0].dir = lane0(r.port[0].dir, i_avs_writedata,
                                                      i_avs_byteenable);
              PIO_OFS_DIR1: next_r.port[1].dir = lane0(r.port[1].dir, i_avs_writedata,
                                                      i_avs_byteenable);
              PIO_OFS_DIR2: next_r.port[2].dir = lane0(r.port[2].dir, i_avs_writedata,
                                                      i_avs_byteenable);
              PIO_OFS_SERCTL: begin
                if (i_avs_byteenable[0]) begin
                  next_r.serctl = i_avs_writedata[2:0];
                end
              end
              default: next_r.serctl = r.serctl;
            endcase
          end
        end
      end
      PIO_DONE: begin
        next_r.state = PIO_IDLE;
      end
      default: next_r.state = PIO_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r.state <= PIO_IDLE;
      for (int p = 0; p < PIO_PORTS; p++) begin
        r.port[p].dir <= PIO_DIR_RST;
        r.port[p].latch <= PIO_DATA_RST;
      end
      r.serctl <= PIO_SERCTL_RST;
      r.rdata <= PIO_RDATA_RST;
    end else begin
      r <= next_r;
    end
  end

  // pin drivers: latch always drives the output, direction gates the enable
  assign o_first_port_pins = r.port[0].latch;
  assign o_first_port_pins_oe = r.port[0].dir;
  assign o_second_port_pins = r.port[1].latch;
  assign o_second_port_pins_oe = r.port[1].dir;
  assign o_third_port_pins = r.port[2].latch;
  assign o_third_port_pins_oe = r.port[2].dir;

  assign o_avs_readdata = r.rdata;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) && (r.state == PIO_IDLE);
  assign o_async_serial_rx_en = r.serctl[PIO_SERCTL_RXEN];
  assign o_async_serial_tx_en = r.serctl[PIO_SERCTL_TXEN];
  assign o_spi_en = r.serctl[PIO_SERCTL_SPIEN];

endmodule : pio_top

// File: verif/pio_top_asserts.sv
// assertion checker for the parallel io ports block
`timescale 1ns/1ps
module pio_chk
  import pio_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [7:0] o_first_port_pins,
  input wire logic [7:0] o_first_port_pins_oe
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  logic [3:0] a;
  logic tw;
  assign a = i_avs_address[5:2];
  // a request seen while waitrequest is high is the one the slave takes
  assign tw = i_avs_write && o_avs_waitrequest && i_avs_byteenable[0];
  wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=>
    !o_avs_waitrequest) else $error("no answer after one wait cycle");
  dir_write_a: assert property (tw && a == PIO_OFS_DIR0 |=>
    {24'h0, o_first_port_pins_oe} == ($past(i_avs_writedata) & 32'hFF)) else $error("dir lost");
  latch_write_a: assert property (tw && a == PIO_OFS_DATA0 |=>
    {24'h0, o_first_port_pins} == ($past(i_avs_writedata) & 32'hFF)) else $error("latch lost");
  rst_dir_a: assert property ($past(i_sys_rst) |-> o_first_port_pins_oe == PIO_DIR_RST)
    else $error("dir not cleared by reset");
  dir_hold_a: assert property (!(tw && a == PIO_OFS_DIR0) |=> $stable(o_first_port_pins_oe))
    else $error("dir changed without write");
  latch_hold_a: assert property (!(tw && a == PIO_OFS_DATA0) |=> $stable(o_first_port_pins))
    else $error("latch changed without write");
  unmapped_a: assert property (i_avs_read && o_avs_waitrequest && a == 4'hF |=>
    o_avs_readdata == PIO_UNMAPPED) else $error("unmapped read not zero");
  upper_zero_a: assert property (i_avs_read && !o_avs_waitrequest |->
    o_avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  cover property (tw && a == PIO_OFS_DIR0);
  cover property (tw && a == PIO_OFS_DATA0);
  cover property (i_avs_read && o_avs_waitrequest && a == PIO_OFS_FIXED);
endmodule : pio_chk
bind pio_top pio_chk u_chk (.*);

// File: verif/pio_board.sv
// board model on the three bidirectional ports
`timescale 1ns/1ps
module pio_board (
  input wire logic [23:0] i_oe,
  input wire logic [23:0] i_out,
  input wire logic [23:0] i_ext,
  input wire logic i_fight,
  output logic [23:0] o_pins
);
  // a stiff load overpowers driven lines, so pin and latch can differ
  assign o_pins = i_fight ? i_ext : (i_oe & i_out) | (~i_oe & i_ext);
endmodule : pio_board

// File: verif/pio_top_tb_top.sv
// testbench for the parallel io ports block
`timescale 1ns/1ps
module pio_top_tb_top
  import pio_pkg::*;
;
  logic clk = 0, rst = 1, rd = 0, wr = 0, wq, fg = 0;
  logic [5:0] adr = 0;
  logic [31:0] wd = 0, rdata, q;
  logic [7:0] fxp = 8'hFF, f;
  logic [3:0] be = 4'h1;
  logic [2:0] ser;
  logic [23:0] ext = 24'hC3A53C, oe, po, pin;
  int fails = 0, n_compared = 0;
  pio_top uut (.i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wq), .i_first_port_pins(pin[7:0]), .o_first_port_pins(po[7:0]),
    .o_first_port_pins_oe(oe[7:0]), .i_second_port_pins(pin[15:8]),
    .o_second_port_pins(po[15:8]), .o_second_port_pins_oe(oe[15:8]),
    .i_third_port_pins(pin[23:16]), .o_third_port_pins(po[23:16]),
    .o_third_port_pins_oe(oe[23:16]), .i_fixed_input_port_pins(fxp),
    .o_async_serial_rx_en(ser[0]), .o_async_serial_tx_en(ser[1]), .o_spi_en(ser[2]));
  pio_board board (.i_oe(oe), .i_out(po), .i_ext(ext), .i_fight(fg), .o_pins(pin));
  initial forever #5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // one bus cycle; the request stands until waitrequest is seen low
  task automatic acc(input logic w, input logic [3:0] i, input logic [7:0] d);
    int n;
    @(posedge clk);
    adr <= {i, 2'h0};
    rd <= !w;
    wr <= w;
    wd <= {24'h0, d};
    n = 0;
    // waitrequest is sampled at each rising edge, before that edge's updates land
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    if (wq !== 1'b0) begin
      fails++;
      conclude();
    end
    q = rdata;
    rd <= 0;
    wr <= 0;
  endtask : acc
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    for (int p = 0; p < 3; p++) begin
      acc(0, PIO_OFS_DIR0 + 4'(p), 8'h00);
      chk("dir reset", 32'h0, q);
      acc(0, 4'(p), 8'h00);
      chk("pin in", {24'h0, ext[8*p+:8]}, q);
      acc(1, 4'(p), 8'h5A);
      chk("oe input", 32'h0, {24'h0, oe[8*p+:8]});
      chk("latch", 32'h5A, {24'h0, po[8*p+:8]});
      acc(1, PIO_OFS_DIR0 + 4'(p), 8'hF0);
      acc(0, PIO_OFS_DIR0 + 4'(p), 8'h00);
      chk("dir", 32'hF0, q);
      chk("oe out", 32'hF0, {24'h0, oe[8*p+:8]});
      fg <= 1;
      acc(0, 4'(p), 8'h00);
      chk("mixed", {24'h0, 8'h50 | (ext[8*p+:8] & 8'h0F)}, q);
      fg <= 0;
    end
    for (int c = 0; c < 8; c++) begin
      f = 8'hFF ^ 8'(c * 37);
      fxp <= f;
      acc(1, PIO_OFS_SERCTL, 8'(c));
      chk("ser en", 32'(c), {29'h0, ser});
      acc(0, PIO_OFS_FIXED, 8'h00);
      f = f & 8'hBF & (c[2] ? 8'hC3 : 8'hFF) & (c[1:0] == 2'h3 ? 8'hFC : 8'hFF);
      chk("fixed", {24'h0, f}, q);
    end
    acc(1, 4'hF, 8'hFF);
    acc(0, 4'hF, 8'h00);
    chk("unmapped", 32'h0, q);
    be <= 4'h0;
    acc(1, PIO_OFS_DATA0, 8'hFF);
    chk("no lane", 32'h5A, {24'h0, po[7:0]});
    be <= 4'h1;
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    acc(0, PIO_OFS_DIR0, 8'h00);
    chk("dir rerst", 32'h0, q);
    conclude();
  end
endmodule : pio_top_tb_top
